// ==== hw/spc_map.vh ====
// constants for the serial port mode and baud configuration block
// Function
// - mode byte holds sync/async, rate factor, length, stop bits, parity select and enable
// - mode bits 1:0 both zero select synchronous, otherwise asynchronous
// - in asynchronous format mode bits 1:0 also encode the rate factor
// - asynchronous bit rate equals bit clock input divided by the rate factor
// - software picks factor 1, 16 or 64; device divides the bit clock to match
// - lowest tap runs at 4.8 kHz, or 6.98 kHz with the slow-line option
// - 6.98 kHz tap with factor 64 gives about 110 bits per second
// - transmitter sends nothing unless active-low clear-to-send is low
// - received characters shorter than eight bits have unused upper bits zero
// - transmit and receive clocks each choose internal tap or external clock
// - shared line routed to data-set-ready cannot serve as external transmit clock
// - in current-loop mode the reader control line follows a modem-control output
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
`define SPC_CLK_HZ 200000000
`define SPC_TAP_LO_HZ 4800
`define SPC_TAP_SLOW_HZ 6980
`define SPC_NUM_TAPS 7
`define SPC_MODE_SYNC 2'h0
`define SPC_MODE_X1 2'h1
`define SPC_MODE_X16 2'h2
`define SPC_MODE_X64 2'h3
`define SPC_FACTOR_16 7'h10
`define SPC_FACTOR_64 7'h40
`define SPC_FACTOR_1 7'h01
`define SPC_CMD_TXEN 0
`define SPC_CMD_DTR 1
`define SPC_CMD_RXEN 2
`define SPC_CMD_RTS 5
`define SPC_CMD_IRESET 6
`define SPC_MODE_LEN_LO 2
`define SPC_MODE_PEN 4
`define SPC_MODE_EVEN 5
`define SPC_MODE_STOP_LO 6
`define SPC_MODE_RST 8'h00
`define SPC_CMD_RST 8'h00
`endif

// ==== hw/spc_buf2.v ====
// two-entry valid/ready buffer for received characters
`timescale 1ns/100ps
module spc_buf2 #(
	parameter W = 8
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [W-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [W-1:0] mem_r [0:1];
	reg wp_r;
	reg rp_r;
	reg [1:0] cnt_r;
	wire push = in_valid && (cnt_r != 2'h2);
	wire pop = out_ready && (cnt_r != 2'h0);
	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = mem_r[rp_r];
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
			mem_r[0] <= {W{1'b0}};
			mem_r[1] <= {W{1'b0}};
		end else begin
			if (push) begin
				mem_r[wp_r] <= in_data;
				wp_r <= ~wp_r;
			end
			if (pop)
				rp_r <= ~rp_r;
			if (push && !pop)
				cnt_r <= cnt_r + 2'h1;
			else if (pop && !push)
				cnt_r <= cnt_r - 2'h1;
		end
	end
endmodule

// ==== hw/spc_core.v ====
// serial port: mode/command bytes, tap divider, clock select, async tx and rx
`timescale 1ns/100ps
`include "spc_map.vh"
module spc_core #(
	parameter CLK_HZ = `SPC_CLK_HZ,
	parameter TOP_HZ = `SPC_TAP_LO_HZ * 64,
	parameter SLOW_TOP_HZ = `SPC_TAP_SLOW_HZ * 64
) (
	input wire clk,
	input wire rst,
	input wire [7:0] ctl_data,
	input wire ctl_wr,
	input wire [2:0] tap_sel,
	input wire slow_line_sel,
	input wire tx_ext_sel,
	input wire rx_ext_sel,
	input wire shared_to_dsr,
	input wire current_loop,
	input wire tx_bit_clock_in,
	input wire rx_bit_clock_in,
	input wire [7:0] tx_data,
	input wire tx_valid,
	output reg tx_ready_r,
	output reg txd_r,
	input wire rxd,
	input wire cts_n,
	output reg rts_n_r,
	output reg dtr_n_r,
	output reg reader_ctl_r,
	output reg [7:0] rx_data_r,
	output reg rx_valid_r,
	input wire rx_ready,
	output reg mode_async_r,
	output reg mode_done_r
);
	localparam [31:0] HALF_TOP = CLK_HZ / (2 * TOP_HZ);
	localparam [31:0] HALF_SLOW = CLK_HZ / (2 * SLOW_TOP_HZ);
	localparam ST_IDLE = 2'h0;
	localparam ST_SHIFT = 2'h1;
	reg [7:0] mode_r;
	reg [7:0] cmd_r;
	reg [31:0] src_cnt_r;
	reg src_r;
	reg [`SPC_NUM_TAPS-1:0] tap_r;
	reg [2:0] s_txc_r, s_rxc_r, s_rxd_r, s_cts_r;
	reg tick_tx_prev_r, tick_rx_prev_r;
	reg [6:0] tx_div_r, rx_div_r;
	reg [1:0] tx_st_r;
	reg [10:0] tx_sh_r;
	reg [3:0] tx_n_r;
	reg [1:0] rx_st_r;
	reg [7:0] rx_sh_r;
	reg [3:0] rx_n_r;
	reg [7:0] bw_data_r;
	reg bw_valid_r;
	wire bw_ready;
	wire [7:0] b_data;
	wire b_valid;
	// both mode bits zero means synchronous
	wire is_sync = (mode_r[1:0] == `SPC_MODE_SYNC);
	wire [6:0] factor = (mode_r[1:0] == `SPC_MODE_X64) ? `SPC_FACTOR_64 :
		(mode_r[1:0] == `SPC_MODE_X16) ? `SPC_FACTOR_16 : `SPC_FACTOR_1;
	wire [3:0] nbits = 4'h5 + {2'h0, mode_r[3:2]};
	// tap 0 is the fastest, each higher tap half the rate of the one below
	wire tap_clk = tap_r[tap_sel];
	// external transmit clock unusable while shared line feeds data-set-ready
	wire tx_src = (tx_ext_sel && !shared_to_dsr) ? s_txc_r[2] : tap_clk;
	wire rx_src = rx_ext_sel ? s_rxc_r[2] : tap_clk;
	wire tx_edge = tx_src && !tick_tx_prev_r;
	wire rx_edge = rx_src && !tick_rx_prev_r;
	wire tx_bit = tx_edge && (tx_div_r == factor - 7'h1);
	wire rx_half = rx_edge && (rx_div_r == (factor >> 1));
	wire rx_bit = rx_edge && (rx_div_r == factor - 7'h1);
	wire par_tx = ^(tx_data & ~(8'hff << nbits)) ^ ~mode_r[`SPC_MODE_EVEN];
	spc_buf2 #(.W(8)) u_buf (
		.clk(clk),
		.rst(rst),
		.in_data(bw_data_r),
		.in_valid(bw_valid_r),
		.in_ready(bw_ready),
		.out_data(b_data),
		.out_valid(b_valid),
		.out_ready(!rx_valid_r)
	);
	// control bytes: first after reset or after an internal-reset command is mode, later ones are commands
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_r <= `SPC_MODE_RST;
			cmd_r <= `SPC_CMD_RST;
			mode_done_r <= 1'b0;
			mode_async_r <= 1'b0;
		end else if (ctl_wr) begin
			if (!mode_done_r) begin
				mode_r <= ctl_data;
				mode_done_r <= 1'b1;
				mode_async_r <= (ctl_data[1:0] != `SPC_MODE_SYNC);
			end else if (ctl_data[`SPC_CMD_IRESET]) begin
				mode_done_r <= 1'b0;
				cmd_r <= `SPC_CMD_RST;
			end else begin
				cmd_r <= ctl_data;
			end
		end
	end
	// common source and divide-by-two tap chain
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			src_cnt_r <= 32'h0;
			src_r <= 1'b0;
			tap_r <= {`SPC_NUM_TAPS{1'b0}};
		end else begin
			if (src_cnt_r >= (slow_line_sel ? HALF_SLOW : HALF_TOP) - 32'h1) begin
				src_cnt_r <= 32'h0;
				src_r <= ~src_r;
				tap_r <= tap_r + {{(`SPC_NUM_TAPS-1){1'b0}}, 1'b1};
			end else begin
				src_cnt_r <= src_cnt_r + 32'h1;
			end
		end
	end
	// pin synchronisers and modem outputs
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_txc_r <= 3'h0;
			s_rxc_r <= 3'h0;
			s_rxd_r <= 3'h7;
			s_cts_r <= 3'h7;
			tick_tx_prev_r <= 1'b0;
			tick_rx_prev_r <= 1'b0;
			rts_n_r <= 1'b1;
			dtr_n_r <= 1'b1;
			reader_ctl_r <= 1'b1;
		end else begin
			s_txc_r <= {s_txc_r[1:0], tx_bit_clock_in};
			s_rxc_r <= {s_rxc_r[1:0], rx_bit_clock_in};
			s_rxd_r <= {s_rxd_r[1:0], rxd};
			s_cts_r <= {s_cts_r[1:0], cts_n};
			tick_tx_prev_r <= tx_src;
			tick_rx_prev_r <= rx_src;
			rts_n_r <= ~cmd_r[`SPC_CMD_RTS];
			dtr_n_r <= ~cmd_r[`SPC_CMD_DTR];
			reader_ctl_r <= current_loop ? ~cmd_r[`SPC_CMD_DTR] : 1'b1;
		end
	end
	// transmitter
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_st_r <= ST_IDLE;
			tx_sh_r <= 11'h7ff;
			tx_n_r <= 4'h0;
			tx_div_r <= 7'h0;
			txd_r <= 1'b1;
			tx_ready_r <= 1'b0;
		end else begin
			if (tx_edge)
				tx_div_r <= (tx_div_r == factor - 7'h1) ? 7'h0 : tx_div_r + 7'h1;
			tx_ready_r <= 1'b0;
			case (tx_st_r)
			ST_IDLE: begin
				txd_r <= 1'b1;
				if (tx_valid && mode_done_r && cmd_r[`SPC_CMD_TXEN] && !s_cts_r[2]) begin
					tx_ready_r <= 1'b1;
					tx_sh_r <= {2'h3, par_tx, tx_data};
					tx_n_r <= 4'h0;
					tx_div_r <= 7'h0;
					tx_st_r <= ST_SHIFT;
					txd_r <= 1'b0;
				end
			end
			ST_SHIFT: begin
				if (tx_bit) begin
					if (tx_n_r == nbits + {3'h0, mode_r[`SPC_MODE_PEN]} +
						{3'h0, mode_r[`SPC_MODE_STOP_LO + 1]}) begin
						tx_st_r <= ST_IDLE;
						txd_r <= 1'b1;
					end else begin
						if (tx_n_r < nbits)
							txd_r <= tx_sh_r[tx_n_r[2:0]];
						else if (tx_n_r == nbits && mode_r[`SPC_MODE_PEN])
							txd_r <= tx_sh_r[8];
						else
							txd_r <= 1'b1;
						tx_n_r <= tx_n_r + 4'h1;
					end
				end
			end
			default: tx_st_r <= ST_IDLE;
			endcase
		end
	end
	// receiver, samples at mid bit
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_st_r <= ST_IDLE;
			rx_sh_r <= 8'h0;
			rx_n_r <= 4'h0;
			rx_div_r <= 7'h0;
			bw_data_r <= 8'h0;
			bw_valid_r <= 1'b0;
		end else begin
			if (rx_edge)
				rx_div_r <= (rx_div_r == factor - 7'h1) ? 7'h0 : rx_div_r + 7'h1;
			if (bw_valid_r && bw_ready)
				bw_valid_r <= 1'b0;
			case (rx_st_r)
			ST_IDLE: begin
				if (!s_rxd_r[2] && mode_done_r && cmd_r[`SPC_CMD_RXEN]) begin
					rx_div_r <= 7'h0;
					rx_n_r <= 4'h0;
					rx_sh_r <= 8'h0;
					rx_st_r <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (is_sync ? rx_bit : rx_half) begin
					if (rx_n_r == nbits + 4'h1) begin
						// short characters keep zero in unused upper bits
						bw_data_r <= rx_sh_r & ~(8'hff << nbits);
						bw_valid_r <= 1'b1;
						rx_st_r <= ST_IDLE;
					end else begin
						// first sample is the start bit and is not stored
						if (rx_n_r != 4'h0)
							rx_sh_r[rx_n_r[2:0] - 3'h1] <= s_rxd_r[2];
						rx_n_r <= rx_n_r + 4'h1;
					end
				end
			end
			default: rx_st_r <= ST_IDLE;
			endcase
		end
	end
	// output register ahead of the consumer
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_data_r <= 8'h0;
			rx_valid_r <= 1'b0;
		end else if (rx_valid_r) begin
			if (rx_ready)
				rx_valid_r <= 1'b0;
		end else if (b_valid) begin
			rx_data_r <= b_data;
			rx_valid_r <= 1'b1;
		end
	end
endmodule

// ==== test/spc_core_assertions.sv ====
// checker for the serial port core
`timescale 1ns/100ps
module spc_chk (
	input wire clk,
	input wire rst,
	input wire [7:0] ctl_data,
	input wire ctl_wr,
	input wire current_loop,
	input wire tx_ready_r,
	input wire txd_r,
	input wire cts_n,
	input wire rts_n_r,
	input wire dtr_n_r,
	input wire reader_ctl_r,
	input wire [7:0] rx_data_r,
	input wire rx_valid_r,
	input wire rx_ready,
	input wire mode_async_r,
	input wire mode_done_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_CTS: assert property (cts_n [*5] |=> !tx_ready_r)
		else $error("send without clear");
	AST_START: assert property ($rose(tx_ready_r) |-> !txd_r)
		else $error("no start bit");
	AST_PULSE: assert property (tx_ready_r |=> !tx_ready_r)
		else $error("ready held");
	AST_RTS: assert property (ctl_wr && mode_done_r && !ctl_data[6] |-> ##2 rts_n_r == !$past(ctl_data[5], 2))
		else $error("send request wrong");
	AST_DTR: assert property (ctl_wr && mode_done_r && !ctl_data[6] |-> ##2 dtr_n_r == !$past(ctl_data[1], 2))
		else $error("terminal ready wrong");
	AST_READER: assert property ((current_loop && $stable(dtr_n_r)) [*3] |-> reader_ctl_r == dtr_n_r)
		else $error("reader control wrong");
	AST_MODE: assert property (ctl_wr && !mode_done_r |=> mode_done_r)
		else $error("mode not taken");
	AST_ASYNC: assert property (ctl_wr && !mode_done_r |=> mode_async_r == ($past(ctl_data[1:0]) != 2'h0))
		else $error("format wrong");
	AST_IDLE: assert property (!mode_done_r |-> txd_r)
		else $error("line not idle");
	AST_HOLD: assert property (rx_valid_r && !rx_ready |=> rx_valid_r && $stable(rx_data_r))
		else $error("word lost");
endmodule
bind spc_core spc_chk chk (.*);

// ==== test/spc_line.sv ====
// far-side serial line: drives rxd, loops send request, decodes txd
`timescale 1ns/100ps
module spc_line (
	input wire clk,
	input wire loop,
	input wire rts_n,
	input wire txd,
	output reg rxd,
	output wire cts_n
);
	assign cts_n = loop ? rts_n : 1'b1;
	initial rxd = 1'b1;
	task send(input [7:0] d, input int n, input int p);
		int i;
		for (i = -1; i <= n; i++) begin
			@(posedge clk);
			rxd <= i < 0 ? 1'b0 : i == n ? 1'b1 : d[i];
			repeat (p - 1) @(posedge clk);
		end
	endtask
	task recv(input int n, input int p, output [7:0] d, output int m);
		int i;
		d = 8'h01;
		m = 0;
		while (!txd) @(posedge clk);
		while (txd) begin
			@(posedge clk);
			m++;
		end
		repeat (p / 2) @(posedge clk);
		for (i = 1; i < n; i++) begin
			d[i] = txd;
			repeat (p) @(posedge clk);
		end
	endtask
endmodule

// ==== test/spc_core_tb.sv ====
// testbench for the serial port core
`timescale 1ns/100ps
module spc_core_tb;
	logic clk = 0, rst = 1, ctl_wr = 0, slow_line_sel = 0, tx_ext_sel = 0, rx_ext_sel = 0;
	logic shared_to_dsr = 0, current_loop = 1, xck = 0, tx_valid = 0, rx_ready = 0;
	logic [7:0] ctl_data = 8'h00, tx_data = 8'h00, d, g;
	logic [2:0] tap_sel = 3'h0;
	logic [10:0] cfg;
	logic [10:0] tbl [7] = '{11'h00f, 11'h002, 11'h029, 11'h086, 11'h186, 11'h20e, 11'h40e};
	wire tx_bit_clock_in = xck;
	wire rx_bit_clock_in = xck;
	wire tx_ready_r, txd_r, rxd, cts_n, rts_n_r, dtr_n_r, reader_ctl_r, rx_valid_r;
	wire mode_async_r, mode_done_r;
	wire [7:0] rx_data_r;
	int n_fail = 0, num_checks = 0, cyc = 0, ec = 0, f, n, p, q, m, k, b;
	spc_core #(.TOP_HZ(10000000), .SLOW_TOP_HZ(8000000)) dut (.*);
	spc_line line (.clk(clk), .loop(current_loop), .rts_n(rts_n_r), .txd(txd_r), .rxd(rxd),
		.cts_n(cts_n));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ec <= ec == 14 ? 0 : ec + 1;
		if (ec == 14) xck <= ~xck;
		if (cyc == 95000) begin
			n_fail++;
			end_of_test;
		end
	end
	task chk(input [31:0] gv, input [31:0] ev);
		num_checks++;
		if (gv !== ev) begin
			n_fail++;
			$display("[ERR] t=%0t got %0h exp %0h", $time, gv, ev);
		end
	endtask
	task wr(input [7:0] v);
		@(posedge clk);
		ctl_data <= v;
		ctl_wr <= 1'b1;
		@(posedge clk);
		ctl_wr <= 1'b0;
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	function [7:0] msk(input [7:0] v, input [1:0] l);
		msk = v & (8'hff >> (2'h3 - l));
	endfunction
	initial begin
		k = $urandom(69);
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		wr(8'h0c);
		@(posedge clk);
		chk(mode_async_r, 0);
		for (int i = 0; i < 9; i++) begin
			cfg = i < 7 ? tbl[i] : {7'h00, 2'($urandom), 2'h1};
			{current_loop, slow_line_sel, shared_to_dsr, tx_ext_sel, rx_ext_sel, tap_sel} <=
				{~cfg[10], cfg[9:7], cfg[7], cfg[6:4]};
			f = cfg[1:0] == 2'h1 ? 1 : cfg[1:0] == 2'h2 ? 16 : 64;
			n = 5 + cfg[3:2];
			b = (cfg[9] ? 24 : 20) << cfg[6:4];
			p = f * (cfg[7] && !cfg[8] ? 30 : b);
			q = f * (cfg[7] ? 30 : b);
			wr(8'h40);
			wr({4'h4, cfg[3:0]});
			wr(8'h27);
			repeat (3) @(posedge clk);
			chk(rts_n_r, 0);
			d = $urandom;
			d[1:0] = 2'h1;
			@(posedge clk);
			tx_data <= d;
			tx_valid <= 1'b1;
			for (k = 0; k < 40 && tx_ready_r !== 1'b1; k++) @(posedge clk);
			tx_valid <= 1'b0;
			chk(k < 40, !cfg[10]);
			if (k < 40) begin
				line.recv(n, p, g, m);
				chk(m, p);
				chk(g, msk(d, cfg[3:2]));
			end
			if (f > 1) begin
				d = $urandom;
				line.send(d, n, q);
				repeat (q) @(posedge clk);
				chk(rx_valid_r, 1);
				chk(rx_data_r, msk(d, cfg[3:2]));
				rx_ready <= 1'b1;
				@(posedge clk);
				rx_ready <= 1'b0;
				@(posedge clk);
				chk(rx_valid_r, 0);
			end
		end
		end_of_test;
	end
endmodule
